// ===== shared/sfl_defines.svh
/*
 serial flash lane front end: commands, address map fields, pin timing counts.
 assumes a 125 MHz host clock and a free design of SCK by the host end.
*/
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH
`define SFL_CMD_DUAL_OUT   8'h3b
`define SFL_CMD_DUAL_IO    8'hbb
`define SFL_CMD_QUAD_OUT   8'h6b
`define SFL_CMD_QUAD_IO    8'heb
`define SFL_CMD_RST_EN     8'h66
`define SFL_CMD_RST        8'h99
`define SFL_ADDR_TOP       24'h03ffff
`define SFL_SEC_LSB        12
`define SFL_HALF_LSB       15
`define SFL_BLK_LSB        16
`define SFL_CLK_MHZ        125
`define SFL_SCK_DIV        4
`define SFL_RST_PULSE_NS   1000
`define SFL_RST_PULSE_CYC  ((`SFL_RST_PULSE_NS * `SFL_CLK_MHZ + 999) / 1000)
`define SFL_TRST_US        300
`define SFL_TRST_CYC       (`SFL_TRST_US * `SFL_CLK_MHZ)
`define SFL_DUMMY_CYC      8
`define SFL_PFS_RESET      1'b0
`endif

// ===== shared/sfl_if.sv
/*
 serial flash link: select, clock and four two-way lanes.
 resolves each lane itself from the two enables, device end first; undriven reads high.
*/
`timescale 1ns/100ps
interface sfl_if;
   logic       sck;
   logic       cs_n;
   logic [3:0] h_o;
   logic [3:0] h_oe;
   logic [3:0] d_o;
   logic [3:0] d_oe;
   logic [3:0] lane;
   // wired lanes, pulled high when nobody drives
   genvar g;
   for (g = 0; g < 4; g++) begin : g_lane
      assign lane[g] = d_oe[g] ? d_o[g] : (h_oe[g] ? h_o[g] : 1'b1);
   end
   modport host (output sck, output cs_n, output h_o, output h_oe, input lane);
   modport dev  (input sck, input cs_n, output d_o, output d_oe, input lane);
endinterface : sfl_if

// ===== shared/sfl_pkg.sv
/*
 serial flash lane front end: shared types.
 assumes sfl_defines.svh for numbers.
*/
package sfl_pkg;
   typedef enum logic [2:0] {
      SFL_CMD = 3'b000,
      SFL_ADR = 3'b001,
      SFL_DMY = 3'b011,
      SFL_DAT = 3'b010,
      SFL_IGN = 3'b110
   } sfl_phase_t;
   typedef enum logic [1:0] {
      SFL_W1 = 2'b00,
      SFL_W2 = 2'b01,
      SFL_W4 = 2'b11
   } sfl_width_t;
endpackage : sfl_pkg

// ===== src/sfl_dev.sv
/*
 device end: mode 0/3 shifting, 2/4 lane fast reads, shared pin use,
 software and pin reset, address map decode.
 assumes a host that drives SCK and select; link logic runs on SCK, reset timing on CLK_IN.
*/
// How it works
// - quad off: pin is pause or reset
// - quad on: pin is lane three only
// - host leaves pin alone while quad on
// - pause only selected, keeps bit count
// - pause starts on pin fall, SCK low
// - reset mode: low pin resets device
// - undriven pin reads high
// - 64 sectors, 32K halves, 64K blocks
// - modes 0 and 3 both work
// - sample rising, shift falling
// - dual reads use lanes zero, one
// - quad reads use four lanes
// - quad only with quad enable set
// - factory default pause; reset needs 1 us low
// - pause ends on rise, SCK low; output off
// - enable then reset; busy 300 us
`timescale 1ns/100ps
`include "sfl_defines.svh"
module sfl_dev
   import sfl_pkg::*;
   (
   // host clock for reset timing
   input  wire logic        CLK_IN,
   input  wire logic        RSTN_IN,
   // configuration bits
   input  wire logic        QUAD_EN_IN,
   input  wire logic        PIN_FUNC_IN,
   // link
   sfl_if.dev               LINK,
   // decoded access
   output logic [23:0]      ADDR_OUT,
   output logic [5:0]       SECTOR_OUT,
   output logic [2:0]       HALF_OUT,
   output logic [1:0]       BLOCK_OUT,
   output logic             ADDR_VALID_OUT,
   output logic [7:0]       CMD_OUT,
   output logic             BUSY_OUT,
   output logic             PAUSED_OUT,
   // read data source
   input  wire logic [7:0]  RD_DATA_IN
   );
   // reset pin filter and busy timer on CLK_IN
   logic        hp_s1_r, hp_s2_r;
   logic [17:0] low_cnt_r, low_cnt_nxt;
   logic [17:0] busy_cnt_r, busy_cnt_nxt;
   logic        swr_t_s1_r, swr_t_s2_r, swr_t_s3_r;
   logic        busy_s1_r, busy_s2_r;
   logic        hw_rst;
   logic        swr_tog_r, swr_tog_nxt;
   logic        pin_rst_mode;
   assign pin_rst_mode = !QUAD_EN_IN && PIN_FUNC_IN;
   always_comb begin
      low_cnt_nxt  = (pin_rst_mode && !hp_s2_r) ?
                     ((low_cnt_r == 18'(`SFL_RST_PULSE_CYC)) ? low_cnt_r : low_cnt_r + 18'd1)
                     : 18'd0;
      busy_cnt_nxt = busy_cnt_r;
      if (hw_rst || (swr_t_s3_r != swr_t_s2_r))
         busy_cnt_nxt = 18'(`SFL_TRST_CYC);
      else if (busy_cnt_r != 18'd0)
         busy_cnt_nxt = busy_cnt_r - 18'd1;
   end
   assign hw_rst = low_cnt_r == 18'(`SFL_RST_PULSE_CYC);
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         hp_s1_r <= 1'b1;
         hp_s2_r <= 1'b1;
         low_cnt_r <= 18'd0;
         busy_cnt_r <= 18'd0;
         swr_t_s1_r <= 1'b0;
         swr_t_s2_r <= 1'b0;
         swr_t_s3_r <= 1'b0;
      end else begin
         hp_s1_r <= LINK.lane[3];
         hp_s2_r <= hp_s1_r;
         low_cnt_r <= low_cnt_nxt;
         busy_cnt_r <= busy_cnt_nxt;
         swr_t_s1_r <= swr_tog_r;
         swr_t_s2_r <= swr_t_s1_r;
         swr_t_s3_r <= swr_t_s2_r;
      end
   end
   assign BUSY_OUT = (busy_cnt_r != 18'd0) || hw_rst;

   // pause latch: only edges of pin while SCK low
   logic hold_r;
   logic hold_on;
   assign hold_on = !QUAD_EN_IN && !PIN_FUNC_IN;
   always_ff @(negedge LINK.lane[3] or posedge LINK.lane[3] or posedge LINK.cs_n) begin
      if (LINK.cs_n)
         hold_r <= 1'b0;
      else if (hold_on && !LINK.sck)
         hold_r <= !LINK.lane[3];
   end
   assign PAUSED_OUT = hold_r;

   // busy seen on the link clock
   always_ff @(posedge LINK.sck or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
      end else begin
         busy_s1_r <= BUSY_OUT;
         busy_s2_r <= busy_s1_r;
      end
   end

   // link-side sequencer on rising SCK
   sfl_phase_t  ph_r, ph_nxt;
   sfl_width_t  w_r, w_nxt;
   logic [7:0]  cmd_r, cmd_nxt;
   logic [23:0] adr_r, adr_nxt;
   logic [5:0]  cnt_r, cnt_nxt;
   logic        wide_adr_r, wide_adr_nxt;
   logic        arm_r, arm_nxt;
   logic        av_r, av_nxt;
   logic [7:0]  cmd_shift;
   logic [3:0]  in_bits;
   logic        srst;
   assign srst = !RSTN_IN || hw_rst;
   assign in_bits = LINK.lane;
   assign cmd_shift = {cmd_r[6:0], in_bits[0]};
   always_comb begin
      ph_nxt = ph_r;
      w_nxt = w_r;
      cmd_nxt = cmd_r;
      adr_nxt = adr_r;
      cnt_nxt = cnt_r + 6'd1;
      wide_adr_nxt = wide_adr_r;
      arm_nxt = arm_r;
      av_nxt = av_r;
      swr_tog_nxt = swr_tog_r;
      unique case (ph_r)
         SFL_CMD: begin
            cmd_nxt = cmd_shift;
            if (cnt_r == 6'd7) begin
               cnt_nxt = 6'd0;
               ph_nxt = SFL_IGN;
               arm_nxt = 1'b0;
               if (busy_s2_r)
                  ph_nxt = SFL_IGN;
               else if (cmd_shift == `SFL_CMD_RST_EN)
                  arm_nxt = 1'b1;
               else if (cmd_shift == `SFL_CMD_RST && arm_r)
                  swr_tog_nxt = !swr_tog_r;
               else if (cmd_shift == `SFL_CMD_DUAL_OUT || cmd_shift == `SFL_CMD_DUAL_IO) begin
                  ph_nxt = SFL_ADR;
                  w_nxt = SFL_W2;
                  wide_adr_nxt = cmd_shift == `SFL_CMD_DUAL_IO;
               end else if ((cmd_shift == `SFL_CMD_QUAD_OUT || cmd_shift == `SFL_CMD_QUAD_IO)
                            && QUAD_EN_IN) begin
                  ph_nxt = SFL_ADR;
                  w_nxt = SFL_W4;
                  wide_adr_nxt = cmd_shift == `SFL_CMD_QUAD_IO;
               end
            end
         end
         SFL_ADR: begin
            if (!wide_adr_r)
               adr_nxt = {adr_r[22:0], in_bits[0]};
            else if (w_r == SFL_W2)
               adr_nxt = {adr_r[21:0], in_bits[1:0]};
            else
               adr_nxt = {adr_r[19:0], in_bits};
            if ((!wide_adr_r && cnt_r == 6'd23) || (wide_adr_r && w_r == SFL_W2 && cnt_r == 6'd11)
                || (wide_adr_r && w_r == SFL_W4 && cnt_r == 6'd5)) begin
               cnt_nxt = 6'd0;
               ph_nxt = SFL_DMY;
               av_nxt = adr_nxt <= `SFL_ADDR_TOP;
            end
         end
         SFL_DMY: begin
            if (cnt_r == 6'(`SFL_DUMMY_CYC - 1)) begin
               cnt_nxt = 6'd0;
               ph_nxt = SFL_DAT;
            end
         end
         SFL_DAT: cnt_nxt = cnt_r;
         SFL_IGN: cnt_nxt = cnt_r;
      endcase
   end
   always_ff @(posedge LINK.sck or posedge LINK.cs_n or posedge srst) begin
      if (srst || LINK.cs_n) begin
         ph_r <= SFL_CMD;
         w_r <= SFL_W1;
         cnt_r <= 6'd0;
         wide_adr_r <= 1'b0;
      end else if (!hold_r) begin
         ph_r <= ph_nxt;
         w_r <= w_nxt;
         cnt_r <= cnt_nxt;
         wide_adr_r <= wide_adr_nxt;
      end
   end
   // decoded command and address outlive the frame for the user
   always_ff @(posedge LINK.sck or posedge srst) begin
      if (srst) begin
         cmd_r <= 8'h00;
         adr_r <= 24'h000000;
         av_r <= 1'b0;
      end else if (!LINK.cs_n && !hold_r) begin
         cmd_r <= cmd_nxt;
         adr_r <= adr_nxt;
         av_r <= av_nxt;
      end
   end
   // reset arming survives deselect, needs consecutive commands
   always_ff @(posedge LINK.sck or posedge srst) begin
      if (srst) begin
         arm_r <= 1'b0;
         swr_tog_r <= 1'b0;
      end else if (!LINK.cs_n && !hold_r) begin
         arm_r <= (ph_r == SFL_CMD) ? arm_nxt : arm_r;
         swr_tog_r <= swr_tog_nxt;
      end
   end
   assign ADDR_OUT = adr_r;
   assign SECTOR_OUT = adr_r[`SFL_HALF_LSB+2:`SFL_SEC_LSB];
   assign HALF_OUT = adr_r[`SFL_BLK_LSB+1:`SFL_HALF_LSB];
   assign BLOCK_OUT = adr_r[`SFL_BLK_LSB+1:`SFL_BLK_LSB];
   assign ADDR_VALID_OUT = av_r;
   assign CMD_OUT = cmd_r;

   // output shifter on falling SCK; works in mode 0 and 3
   logic [7:0] sh_r;
   logic [3:0] do_r;
   logic       oe_r;
   always_ff @(negedge LINK.sck or posedge LINK.cs_n or posedge srst) begin
      if (srst || LINK.cs_n) begin
         sh_r <= 8'h00;
         do_r <= 4'h0;
         oe_r <= 1'b0;
      end else if (!hold_r) begin
         oe_r <= ph_r == SFL_DAT;
         unique case (w_r)
            SFL_W1: begin
               do_r <= {3'b000, sh_r[7]};
               sh_r <= {sh_r[6:0], 1'b0};
            end
            SFL_W2: begin
               do_r <= {2'b00, sh_r[7:6]};
               sh_r <= (cnt_r[1:0] == 2'd3) ? RD_DATA_IN : {sh_r[5:0], 2'b00};
            end
            SFL_W4: begin
               do_r <= sh_r[7:4];
               sh_r <= {sh_r[3:0], 4'h0};
            end
         endcase
         if (ph_r != SFL_DAT || (w_r == SFL_W4 && !do_r[0]))
            sh_r <= RD_DATA_IN;
      end
   end
   // lane enables follow width; quad off keeps lanes two, three as inputs
   always_comb begin
      LINK.d_o = do_r;
      LINK.d_oe = 4'h0;
      if (oe_r && !hold_r) begin
         unique case (w_r)
            SFL_W1: LINK.d_oe = 4'b0010;
            SFL_W2: LINK.d_oe = 4'b0011;
            SFL_W4: LINK.d_oe = QUAD_EN_IN ? 4'b1111 : 4'b0011;
         endcase
         if (w_r == SFL_W1)
            LINK.d_o = {2'b00, do_r[0], 1'b0};
      end
   end
endmodule : sfl_dev

// ===== src/sfl_host.sv
/*
 host end: makes SCK by division, sends a command, address and reads bytes.
 assumes the device end on the same interface.
*/
`timescale 1ns/100ps
`include "sfl_defines.svh"
module sfl_host
   import sfl_pkg::*;
   (
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RSTN_IN,
   // request
   input  wire logic        REQ_IN,
   input  wire logic [7:0]  CMD_IN,
   input  wire logic [23:0] ADDR_IN,
   input  wire logic [5:0]  NBITS_IN,
   input  wire logic        QUAD_EN_IN,
   input  wire logic        HOLD_IN,
   // answer
   output logic             BUSY_OUT,
   output logic [7:0]       DATA_OUT,
   output logic             DONE_OUT,
   // link
   sfl_if.host              LINK
   );
   logic [1:0]  div_r, div_nxt;
   logic        act_r, act_nxt;
   logic [47:0] sh_r, sh_nxt;
   logic [5:0]  n_r, n_nxt;
   logic [7:0]  dat_r, dat_nxt;
   logic        done_r, done_nxt;
   logic [3:0]  in_s1_r, in_s2_r;
   logic        pause_r, pause_nxt;
   logic [5:0]  span_r, span_nxt;
   // frame engine: one bit per divided SCK period, mode 0; frozen while paused
   always_comb begin
      div_nxt = act_r ? (pause_r ? div_r : div_r + 2'd1) : 2'd0;
      // pause only entered and left with SCK low
      pause_nxt = act_r && HOLD_IN && !QUAD_EN_IN && (pause_r || div_r == 2'd0);
      span_nxt = span_r;
      act_nxt = act_r;
      sh_nxt = sh_r;
      n_nxt = n_r;
      dat_nxt = dat_r;
      done_nxt = 1'b0;
      if (!act_r && REQ_IN) begin
         act_nxt = 1'b1;
         sh_nxt = {CMD_IN, ADDR_IN, 16'h0000};
         n_nxt = NBITS_IN;
         // lane zero released after command and address bits
         if (CMD_IN == `SFL_CMD_DUAL_IO)
            span_nxt = 6'd20;
         else if (CMD_IN == `SFL_CMD_QUAD_IO)
            span_nxt = 6'd14;
         else
            span_nxt = 6'd32;
      end else if (act_r && div_r == 2'd3) begin
         sh_nxt = {sh_r[46:0], 1'b0};
         if (span_r != 6'd0)
            span_nxt = span_r - 6'd1;
         dat_nxt = {dat_r[6:0], in_s2_r[1]};
         n_nxt = n_r - 6'd1;
         if (n_r == 6'd1) begin
            act_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         div_r <= 2'd0;
         act_r <= 1'b0;
         sh_r <= 48'h0;
         n_r <= 6'd0;
         dat_r <= 8'h00;
         done_r <= 1'b0;
         in_s1_r <= 4'hf;
         in_s2_r <= 4'hf;
         pause_r <= 1'b0;
         span_r <= 6'd0;
      end else begin
         pause_r <= pause_nxt;
         span_r <= span_nxt;
         div_r <= div_nxt;
         act_r <= act_nxt;
         sh_r <= sh_nxt;
         n_r <= n_nxt;
         dat_r <= dat_nxt;
         done_r <= done_nxt;
         in_s1_r <= LINK.lane;
         in_s2_r <= in_s1_r;
      end
   end
   assign LINK.sck = act_r && div_r[1];
   assign LINK.cs_n = !act_r;
   assign LINK.h_o = {!HOLD_IN, 2'b11, sh_r[47]};
   // pin three driven low only while quad is off: pause in frame, reset when idle
   assign LINK.h_oe = {!QUAD_EN_IN && HOLD_IN && (pause_r || !act_r), 2'b00,
                       act_r && (span_r != 6'd0)};
   assign BUSY_OUT = act_r;
   assign DATA_OUT = dat_r;
   assign DONE_OUT = done_r;
endmodule : sfl_host

// ===== verif/serial_flash_io_lane_front_end_test.sv
/*
 bench: host and device ends face each other; map, lanes, pause and resets.
 assumes sfl_defines.svh counts and the hand-over timing of both ends.
*/
`timescale 1ns/100ps
`include "sfl_defines.svh"
module serial_flash_io_lane_front_end_test;
   logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, qe = 1'b0, pfs = 1'b0, hold = 1'b0;
   logic [7:0]  cmd = 8'h00;
   logic [23:0] adr = 24'h000000;
   logic [3:0]  seen;
   logic        h_busy, h_done, d_valid, d_busy, d_paused;
   logic [7:0]  d_cmd;
   logic [23:0] d_adr;
   logic [5:0]  d_sec;
   logic [2:0]  d_half;
   logic [1:0]  d_blk;
   int          failures = 0, num_checks = 0, cyc = 0;
   sfl_if lk ();
   sfl_host sfl_host_inst (.CLK_IN(clk), .RSTN_IN(rstn), .REQ_IN(req), .CMD_IN(cmd),
      .ADDR_IN(adr), .NBITS_IN(6'h30), .QUAD_EN_IN(qe), .HOLD_IN(hold), .BUSY_OUT(h_busy),
      .DATA_OUT(), .DONE_OUT(h_done), .LINK(lk));
   sfl_dev sfl_dev_inst (.CLK_IN(clk), .RSTN_IN(rstn), .QUAD_EN_IN(qe), .PIN_FUNC_IN(pfs),
      .LINK(lk), .ADDR_OUT(d_adr), .SECTOR_OUT(d_sec), .HALF_OUT(d_half), .BLOCK_OUT(d_blk),
      .ADDR_VALID_OUT(d_valid), .CMD_OUT(d_cmd), .BUSY_OUT(d_busy), .PAUSED_OUT(d_paused),
      .RD_DATA_IN(8'ha5));
   sfl_link_sva sfl_link_sva_inst (.CLK_IN(clk), .RSTN_IN(rstn), .QUAD_EN_IN(qe),
      .PIN_FUNC_IN(pfs), .sck(lk.sck), .cs_n(lk.cs_n), .h_oe(lk.h_oe), .d_o(lk.d_o),
      .d_oe(lk.d_oe), .lane(lk.lane));
   // 125 MHz clock
   always #4 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         test_done();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk
   // one transfer, noting which device lanes were driven
   task automatic tx(input logic [7:0] c, input logic [23:0] a);
      int n = 0;
      seen = 4'h0;
      @(posedge clk);
      cmd <= c;
      adr <= a;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      while (h_done !== 1'b1 && n < 400) begin
         wait_clk(1);
         seen = seen | lk.d_oe;
         n++;
      end
      chk(24'(n < 400), 24'h1);
   endtask : tx
   // address map fields at sector, half and block edges and one past the top
   task automatic t_map();
      logic [23:0] tbl [7] = '{24'h000000, 24'h000fff, 24'h007000, 24'h008000,
                               24'h01ffff, 24'h03ffff, 24'h040000};
      foreach (tbl[i]) begin
         tx(`SFL_CMD_DUAL_OUT, tbl[i]);
         chk(d_adr, tbl[i]);
         chk(24'(d_sec), 24'(tbl[i][17:12]));
         chk(24'(d_half), 24'(tbl[i][17:15]));
         chk(24'(d_blk), 24'(tbl[i][17:16]));
         chk(24'(d_valid), 24'(tbl[i] <= `SFL_ADDR_TOP));
      end
   endtask : t_map
   // every fast read with quad off and on
   task automatic t_cmds();
      logic [7:0] c [4] = '{`SFL_CMD_DUAL_OUT, `SFL_CMD_DUAL_IO, `SFL_CMD_QUAD_OUT,
                            `SFL_CMD_QUAD_IO};
      for (int q = 0; q < 2; q++) begin
         @(posedge clk);
         qe <= q[0];
         foreach (c[i]) begin
            tx(c[i], 24'h000100);
            chk(24'(seen[1:0]), (i < 2 || q == 1) ? 24'h3 : 24'h0);
            chk(24'(seen[3]), 24'(i > 1 && q == 1));
         end
      end
      @(posedge clk);
      qe <= 1'b0;
   endtask : t_cmds
   // pause in mid transfer keeps the bit count; ignored while deselected
   task automatic t_pause();
      @(posedge clk);
      hold <= 1'b1;
      wait_clk(8);
      chk(24'(d_paused), 24'h0);
      @(posedge clk);
      hold <= 1'b0;
      fork
         tx(`SFL_CMD_DUAL_OUT, 24'h02a5c3);
         begin
            wait_clk(40);
            hold <= 1'b1;
            wait_clk(20);
            chk(24'(d_paused), 24'h1);
            chk(24'(lk.d_oe), 24'h0);
            hold <= 1'b0;
            wait_clk(10);
            chk(24'(d_paused), 24'h0);
         end
      join
      chk(d_adr, 24'h02a5c3);
   endtask : t_pause
   // pin as reset input: long low pulse resets, no pause
   task automatic t_pinrst();
      int n = 0;
      @(posedge clk);
      pfs <= 1'b1;
      hold <= 1'b1;
      wait_clk(`SFL_RST_PULSE_CYC + 5);
      chk(24'(d_busy), 24'h1);
      chk(24'(d_paused), 24'h0);
      hold <= 1'b0;
      while (d_busy !== 1'b0 && n < 40000) begin
         wait_clk(1);
         n++;
      end
      @(posedge clk);
      pfs <= 1'b0;
   endtask : t_pinrst
   // enable then reset: busy, commands refused, then accepted again
   task automatic t_swrst();
      int n = 0;
      tx(`SFL_CMD_RST_EN, 24'h000000);
      tx(`SFL_CMD_RST, 24'h000000);
      chk(24'(d_busy), 24'h1);
      tx(`SFL_CMD_DUAL_OUT, 24'h001000);
      chk(d_adr, 24'h000000);
      while (d_busy !== 1'b0 && n < 40000) begin
         wait_clk(1);
         n++;
      end
      chk(24'(n > `SFL_TRST_CYC - 800 && n < `SFL_TRST_CYC), 24'h1);
      tx(`SFL_CMD_DUAL_OUT, 24'h001000);
      chk(24'(d_cmd), 24'(`SFL_CMD_DUAL_OUT));
      chk(d_adr, 24'h001000);
   endtask : t_swrst
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_map();
      t_cmds();
      t_pause();
      t_pinrst();
      t_swrst();
      test_done();
   end
endmodule : serial_flash_io_lane_front_end_test

// ===== verif/sfl_link_sva.sv
/*
 link checker: select, clock shape and lane ownership on the flash link.
 assumes SCK is made from the host clock, so one clock samples everything.
*/
`timescale 1ns/100ps
module sfl_link_sva (
   // clock and reset
   input  wire logic       CLK_IN,
   input  wire logic       RSTN_IN,
   // configuration
   input  wire logic       QUAD_EN_IN,
   input  wire logic       PIN_FUNC_IN,
   // link
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic [3:0] h_oe,
   input  wire logic [3:0] d_o,
   input  wire logic [3:0] d_oe,
   input  wire logic [3:0] lane
   );
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // pin falls as a pause request while clock is low
   sequence hold_fall;
      $fell(lane[3]) && !sck && !cs_n && !QUAD_EN_IN && !PIN_FUNC_IN;
   endsequence
   // clock high for one more host cycle, then low
   sequence sck_pulse;
      sck ##1 !sck;
   endsequence
   // lane ownership and pin roles
   no_contention_a: assert property ((h_oe & d_oe) == 4'h0)
      else $error("lane driven by both ends");
   lane_pullup_a: assert property ((h_oe[3] | d_oe[3]) == 1'b0 |-> lane[3])
      else $error("undriven pin not high");
   quad_pins_a: assert property (!QUAD_EN_IN |-> d_oe[3:2] == 2'b00)
      else $error("upper lanes driven with quad off");
   quad_hold_a: assert property (QUAD_EN_IN |-> !h_oe[3])
      else $error("pin driven as control with quad on");
   // clock mode and framing
   idle_clock_a: assert property (cs_n |-> !sck)
      else $error("clock not idle low when deselected");
   select_lead_a: assert property ($fell(cs_n) |-> !sck)
      else $error("clock high as select falls");
   sck_shape_a: assert property ($rose(sck) |=> sck_pulse)
      else $error("clock pulse width wrong");
   out_falling_a: assert property (!cs_n && d_oe[1] && $stable(d_oe) && $changed(d_o[1])
      |-> $fell(sck))
      else $error("output bit changed off the falling edge");
   pause_quiet_a: assert property (hold_fall ##1 (!lane[3])[*2] |-> d_oe == 4'h0)
      else $error("output driven while paused");
endmodule : sfl_link_sva
